// [tb.sv]
// self-checking bench for the table memory operation engine
`timescale 1ns/10ps
`default_nettype none
`include "tmoe_defs.svh"

module tb;
	// one case: operation, table placement, expected result and two memory words
	typedef struct {
		logic [2:0] op;
		logic [1:0] src;
		logic [15:0] val;
		logic [15:0] base;
		logic [15:0] len;
		logic [15:0] off;
		logic [15:0] eacc;
		logic eflag;
		logic [15:0] a1, v1, a2, v2;
	} tmoe_row_t;

	logic clock, rst_n, start, scan_end, busy, done, table_range_fault_flag, port_clash;
	tmoe_pkg::tmoe_cmd_t cmd;
	tmoe_pkg::tmoe_mem_req_t mem_req;
	logic [31:0] acc_in, stack1_in, stack2_in, acc_out;
	logic [15:0] label_base, mem_rdata;
	int err_total = 0;
	int n_compared = 0;
	tmoe_row_t rows [$];
	logic [15:0] pre [$] = '{16'h0300, 16'h8989, 16'h0301, 16'h9999, 16'h0302, 16'h3074,
		16'h0304, 16'h8989, 16'h0305, 16'h1010, 16'h0306, 16'h7777, 16'h0602, 16'hFFFF,
		16'h0703, 16'h1111, 16'h0710, 16'h5A5A, 16'h0730, 16'h0740, 16'h0740, 16'h3C3C,
		16'h0902, 16'h0001, 16'h0903, 16'h0002, 16'h0904, 16'h0003, 16'h0905, 16'h0004,
		16'h0910, 16'hBEEF, 16'h0801, 16'h2222};

	tmoe_engine tmoe_engine_inst (.clock(clock), .rst_n(rst_n), .start(start), .cmd(cmd),
		.acc_in(acc_in), .stack1_in(stack1_in), .stack2_in(stack2_in),
		.label_base(label_base), .scan_end(scan_end), .mem_rdata(mem_rdata),
		.mem_req(mem_req), .busy(busy), .done(done), .acc_out(acc_out),
		.table_range_fault_flag(table_range_fault_flag));

	tmoe_mem_model tmoe_mem_model_inst (.clock(clock), .mem_req(mem_req),
		.mem_rdata(mem_rdata), .port_clash(port_clash));

	// 125 MHz clock
	initial begin
		clock = 1'h0;
		forever #4 clock = ~clock;
	end

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// present a command just after an edge; wait_done lowers start again
	task automatic issue(input logic [2:0] op, input logic [1:0] src, input logic [15:0] val,
			input logic [31:0] a, input logic [31:0] s1, input logic [31:0] s2);
		@(posedge clock);
		start <= 1'h1;
		cmd <= '{op: tmoe_pkg::tmoe_op_t'(op), src: tmoe_pkg::tmoe_fill_src_t'(src),
			operand: val};
		acc_in <= a;
		stack1_in <= s1;
		stack2_in <= s2;
	endtask : issue

	// returns at the edge closing the done cycle, bounded
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			start <= 1'h0;
			n++;
		end while (done !== 1'h1 && n < 2000);
		check("done", done, 1'h1);
	endtask : wait_done

	task automatic reset_check();
		check("busy", busy, 1'h0);
		check("done", done, 1'h0);
		check("acc_out", acc_out, 32'h00000000);
		check("flag", table_range_fault_flag, 1'h0);
		check("mem_req", mem_req, 34'h000000000);
	endtask : reset_check

	task automatic run_row(input tmoe_row_t r, input int idx);
		logic [31:0] a, s1, s2;
		// parameter placement on accumulator and stack levels depends on the operation
		a = {16'h0000, r.op == 3'h4 ? r.off : r.base};
		s1 = {16'h0000, r.op == 3'h0 ? r.off : r.op == 3'h4 ? r.base : r.len};
		s2 = {16'h0000, r.op == 3'h0 || r.op == 3'h4 ? r.len : 16'h0000};
		issue(r.op, r.src, r.val, a, s1, s2);
		wait_done();
		check("acc_out", acc_out, r.op == 3'h4 ? {16'h0000, r.eacc} : a);
		check("flag", table_range_fault_flag, r.eflag);
		check("word one", tmoe_mem_model_inst.mem[r.a1], r.v1);
		check("word two", tmoe_mem_model_inst.mem[r.a2], r.v2);
		$display("row %0d finished", idx);
	endtask : run_row

	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		results();
	end

	initial begin
		// op codes: 0 copy, 1 bit set, 2 bit clear, 3 fill, 4 search
		rows.push_back('{3'h1, 2'h0, 16'h001C, 16'h0600, 16'h0002, 16'h0000, 16'h0000, 1'h0,
			16'h0601, 16'h1000, 16'h0600, 16'h0000});
		rows.push_back('{3'h1, 2'h0, 16'h000F, 16'h0600, 16'h0002, 16'h0000, 16'h0000, 1'h0,
			16'h0600, 16'h8000, 16'h0601, 16'h1000});
		rows.push_back('{3'h1, 2'h0, 16'h0020, 16'h0600, 16'h0002, 16'h0000, 16'h0000, 1'h1,
			16'h0601, 16'h1000, 16'h0602, 16'hFFFF});
		rows.push_back('{3'h1, 2'h0, 16'h001F, 16'h0600, 16'h0002, 16'h0000, 16'h0000, 1'h0,
			16'h0601, 16'h9000, 16'h0600, 16'h8000});
		rows.push_back('{3'h2, 2'h0, 16'h0000, 16'h0602, 16'h0001, 16'h0000, 16'h0000, 1'h0,
			16'h0602, 16'hFFFE, 16'h0601, 16'h9000});
		rows.push_back('{3'h2, 2'h0, 16'h000F, 16'h0602, 16'h0001, 16'h0000, 16'h0000, 1'h0,
			16'h0602, 16'h7FFE, 16'h0603, 16'h0000});
		rows.push_back('{3'h2, 2'h0, 16'h0010, 16'h0602, 16'h0001, 16'h0000, 16'h0000, 1'h1,
			16'h0602, 16'h7FFE, 16'h0603, 16'h0000});
		rows.push_back('{3'h3, 2'h0, 16'hA5C3, 16'h0700, 16'h0003, 16'h0000, 16'h0000, 1'h1,
			16'h0702, 16'hA5C3, 16'h0703, 16'h1111});
		rows.push_back('{3'h3, 2'h1, 16'h0710, 16'h0720, 16'h0002, 16'h0000, 16'h0000, 1'h1,
			16'h0721, 16'h5A5A, 16'h0722, 16'h0000});
		rows.push_back('{3'h3, 2'h2, 16'h0730, 16'h0750, 16'h0002, 16'h0000, 16'h0000, 1'h1,
			16'h0750, 16'h3C3C, 16'h0752, 16'h0000});
		rows.push_back('{3'h3, 2'h0, 16'h0F0F, 16'h1000, 16'h00FF, 16'h0000, 16'h0000, 1'h1,
			16'h10FE, 16'h0F0F, 16'h10FF, 16'h0000});
		rows.push_back('{3'h0, 2'h0, 16'h0000, 16'h0900, 16'h0004, 16'h0002, 16'h0000, 1'h1,
			16'h0802, 16'h0001, 16'h0805, 16'h0004});
		rows.push_back('{3'h0, 2'h0, 16'h0000, 16'h0910, 16'h0001, 16'h0000, 16'h0000, 1'h1,
			16'h0800, 16'hBEEF, 16'h0801, 16'h2222});
		rows.push_back('{3'h4, 2'h0, 16'h8989, 16'h0300, 16'h0006, 16'h0002, 16'h0004, 1'h0,
			16'h0304, 16'h8989, 16'h0300, 16'h8989});
		rows.push_back('{3'h4, 2'h0, 16'h8989, 16'h0300, 16'h0006, 16'h0005, 16'h0000, 1'h1,
			16'h0305, 16'h1010, 16'h0300, 16'h8989});
		rows.push_back('{3'h4, 2'h0, 16'h7777, 16'h0300, 16'h0006, 16'h0000, 16'h0000, 1'h1,
			16'h0306, 16'h7777, 16'h0300, 16'h8989});
		rows.push_back('{3'h4, 2'h0, 16'h8989, 16'h0300, 16'h0006, 16'h0006, 16'h0000, 1'h1,
			16'h0306, 16'h7777, 16'h0300, 16'h8989});
		rows.push_back('{3'h4, 2'h0, 16'h3074, 16'h0300, 16'h0006, 16'h0000, 16'h0002, 1'h0,
			16'h0302, 16'h3074, 16'h0300, 16'h8989});
		rst_n = 1'h0;
		start = 1'h0;
		scan_end = 1'h0;
		cmd = '0;
		acc_in = 32'h00000000;
		stack1_in = 32'h00000000;
		stack2_in = 32'h00000000;
		label_base = 16'h0800;
		@(posedge clock);
		for (int i = 0; i < pre.size(); i += 2) begin
			tmoe_mem_model_inst.mem[pre[i]] = pre[i+1];
		end
		repeat (5) @(posedge clock);
		reset_check();
		rst_n <= 1'h1;
		$display("test reset finished");
		foreach (rows[i]) begin
			run_row(rows[i], i);
		end
		// search offset comes from the low accumulator half only
		issue(3'h4, 2'h0, 16'h8989, 32'hABCD0002, 32'h00000300, 32'h00000006);
		wait_done();
		check("acc_out", acc_out, 32'h00000004);
		$display("test upper half finished");
		// flag survives a copy, then the scan end clears it
		issue(3'h1, 2'h0, 16'h0020, 32'h00000600, 32'h00000002, 32'h00000000);
		wait_done();
		issue(3'h0, 2'h0, 16'h0000, 32'h00000910, 32'h00000000, 32'h00000001);
		wait_done();
		check("flag", table_range_fault_flag, 1'h1);
		@(posedge clock);
		scan_end <= 1'h1;
		@(posedge clock);
		scan_end <= 1'h0;
		@(posedge clock);
		check("flag", table_range_fault_flag, 1'h0);
		$display("test scan end finished");
		// start while busy is ignored; start in the done cycle is taken
		issue(3'h1, 2'h0, 16'h0020, 32'h00000600, 32'h00000002, 32'h00000000);
		issue(3'h1, 2'h0, 16'h0000, 32'h00000603, 32'h00000001, 32'h00000000);
		issue(3'h4, 2'h0, 16'h8989, 32'h00000002, 32'h00000300, 32'h00000006);
		@(posedge clock);
		start <= 1'h0;
		wait_done();
		check("acc_out", acc_out, 32'h00000004);
		check("flag", table_range_fault_flag, 1'h0);
		check("ignored word", tmoe_mem_model_inst.mem[16'h0603], 16'h0000);
		$display("test back to back finished");
		// reset in the middle of a long fill stops it cold
		issue(3'h3, 2'h0, 16'h1234, 32'h00002000, 32'h000000FF, 32'h00000000);
		repeat (20) begin
			@(posedge clock);
			start <= 1'h0;
		end
		check("busy", busy, 1'h1);
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		reset_check();
		rst_n <= 1'h1;
		repeat (10) @(posedge clock);
		check("fill stopped", tmoe_mem_model_inst.mem[16'h2040], 16'h0000);
		run_row(rows[13], 13);
		check("port clash", port_clash, 1'h0);
		$display("test mid reset finished");
		results();
	end
endmodule : tb
`default_nettype wire

// [tmoe_bit_locate.sv]
// splits a table bit index into word offset and bit mask, with range check
`timescale 1ns/10ps
`default_nettype none
`include "tmoe_defs.svh"

module tmoe_bit_locate #(
	parameter int LEN_BITS = `TMOE_LEN_BITS
) (
	input wire logic [`TMOE_WORD_BITS-1:0] bit_index,
	input wire logic [LEN_BITS-1:0] table_len,
	output logic [`TMOE_WORD_BITS-1:0] word_off,
	output logic [`TMOE_WORD_BITS-1:0] bit_mask,
	output logic in_range
);

	// index n picks word n/16, bit n%16; octal is only how users write n
	assign word_off = bit_index >> `TMOE_BIT_SEL_BITS;
	assign bit_mask = `TMOE_WORD_BITS'(1) << bit_index[`TMOE_BIT_SEL_BITS-1:0];

	// legal indices stop one short of length times 16
	assign in_range = (32'(bit_index) < (32'(table_len) << `TMOE_BIT_SEL_BITS));

endmodule : tmoe_bit_locate
`default_nettype wire

// [tmoe_defs.svh]
// widths, field positions and reset values for the table memory operation engine
`ifndef TMOE_DEFS_SVH
`define TMOE_DEFS_SVH

// data memory word and address width
`define TMOE_WORD_BITS 16
// low bits of a bit index that pick the bit inside a word
`define TMOE_BIT_SEL_BITS 4
// table length field width, lengths 0 to FF
`define TMOE_LEN_BITS 8
// accumulator and stack level width
`define TMOE_ACC_BITS 32
// reset values
`define TMOE_ACC_RST 32'h00000000
`define TMOE_WORD_RST 16'h0000

`endif

// [tmoe_engine.sv]
// table memory operation engine: copy, bit set/clear, fill and search over data memory
`timescale 1ns/10ps
`default_nettype none
`include "tmoe_defs.svh"

module tmoe_engine #(
	parameter int LEN_BITS = `TMOE_LEN_BITS
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic start,
	input wire tmoe_pkg::tmoe_cmd_t cmd,
	input wire logic [`TMOE_ACC_BITS-1:0] acc_in,
	input wire logic [`TMOE_ACC_BITS-1:0] stack1_in,
	input wire logic [`TMOE_ACC_BITS-1:0] stack2_in,
	input wire logic [`TMOE_WORD_BITS-1:0] label_base,
	input wire logic scan_end,
	input wire logic [`TMOE_WORD_BITS-1:0] mem_rdata,
	output tmoe_pkg::tmoe_mem_req_t mem_req,
	output logic busy,
	output logic done,
	output logic [`TMOE_ACC_BITS-1:0] acc_out,
	output logic table_range_fault_flag
);

	// lengths wider than the word would overrun the counters
	if (LEN_BITS < 1 || LEN_BITS > 15) begin : g_bad_len
		$error("tmoe_engine: LEN_BITS must be 1 to 15");
	end

	tmoe_pkg::tmoe_state_t state_reg, state_next;
	tmoe_pkg::tmoe_op_t op_reg, op_next;
	tmoe_pkg::tmoe_fill_src_t src_reg, src_next;
	tmoe_pkg::tmoe_mem_req_t mem_reg, mem_next;
	logic hop_reg, hop_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic flag_reg, flag_next;
	logic [`TMOE_ACC_BITS-1:0] acc_reg, acc_next;
	logic [`TMOE_WORD_BITS-1:0] base_reg, base_next;
	logic [`TMOE_WORD_BITS-1:0] aux_reg, aux_next;
	logic [`TMOE_WORD_BITS-1:0] cnt_reg, cnt_next;
	logic [`TMOE_WORD_BITS-1:0] idx_reg, idx_next;
	logic [`TMOE_WORD_BITS-1:0] data_reg, data_next;
	logic [`TMOE_WORD_BITS-1:0] mask_reg, mask_next;
	logic [`TMOE_WORD_BITS-1:0] addr_reg, addr_next;
	logic [`TMOE_WORD_BITS-1:0] idx_inc, word_off, bit_mask, len1, len2;
	logic in_range;

	// fill, search and bit op table lengths come from the low byte of the stack levels; the copy count takes the low word of stack level 2
	assign len1 = `TMOE_WORD_BITS'(stack1_in[LEN_BITS-1:0]);
	assign len2 = `TMOE_WORD_BITS'(stack2_in[LEN_BITS-1:0]);
	assign idx_inc = idx_reg + `TMOE_WORD_BITS'(1);
	tmoe_bit_locate #(
		.LEN_BITS(LEN_BITS)
	) u_bit_locate (
		.bit_index(cmd.operand),
		.table_len(stack1_in[LEN_BITS-1:0]),
		.word_off(word_off),
		.bit_mask(bit_mask),
		.in_range(in_range)
	);
	// sequencing; every access is one word on the single port
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		src_next = src_reg;
		hop_next = hop_reg;
		acc_next = acc_reg;
		base_next = base_reg;
		aux_next = aux_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		data_next = data_reg;
		mask_next = mask_reg;
		addr_next = addr_reg;
		done_next = 1'b0;
		mem_next = mem_reg;
		mem_next.rd = 1'b0;
		mem_next.we = 1'b0;
		flag_next = flag_reg;
		// scan end clears first, so a flag written by an op this cycle wins
		if (scan_end) begin
			flag_next = 1'b0;
		end
		case (state_reg)
			tmoe_pkg::ST_IDLE: begin
				// starts while busy are not seen: only idle takes a command
				if (start) begin
					op_next = cmd.op;
					src_next = cmd.src;
					hop_next = 1'b0;
					idx_next = '0;
					acc_next = acc_in;
					data_next = cmd.operand;
					case (cmd.op)
						tmoe_pkg::OP_COPY: begin
							// shared offset applies to both ends; no clipping at area end
							base_next = acc_in[`TMOE_WORD_BITS-1:0] + stack1_in[`TMOE_WORD_BITS-1:0];
							aux_next = label_base + stack1_in[`TMOE_WORD_BITS-1:0];
							cnt_next = stack2_in[`TMOE_WORD_BITS-1:0];
							addr_next = acc_in[`TMOE_WORD_BITS-1:0] + stack1_in[`TMOE_WORD_BITS-1:0];
							state_next = (stack2_in[`TMOE_WORD_BITS-1:0] == '0) ?
								tmoe_pkg::ST_FINISH : tmoe_pkg::ST_RD;
						end
						tmoe_pkg::OP_BSET, tmoe_pkg::OP_BCLR: begin
							addr_next = acc_in[`TMOE_WORD_BITS-1:0] + word_off;
							mask_next = bit_mask;
							flag_next = !in_range;
							state_next = in_range ? tmoe_pkg::ST_RD : tmoe_pkg::ST_FINISH;
						end
						tmoe_pkg::OP_FILL: begin
							base_next = acc_in[`TMOE_WORD_BITS-1:0];
							cnt_next = len1;
							addr_next = cmd.operand;
							if (cmd.src != tmoe_pkg::FILL_IMM) begin
								state_next = tmoe_pkg::ST_RD;
							end else begin
								state_next = (len1 == '0) ? tmoe_pkg::ST_FINISH : tmoe_pkg::ST_FILL_WR;
							end
						end
						tmoe_pkg::OP_FIND: begin
							base_next = stack1_in[`TMOE_WORD_BITS-1:0];
							cnt_next = len2;
							idx_next = acc_in[`TMOE_WORD_BITS-1:0];
							addr_next = stack1_in[`TMOE_WORD_BITS-1:0] + acc_in[`TMOE_WORD_BITS-1:0];
							if (acc_in[`TMOE_WORD_BITS-1:0] >= len2) begin // outside: no access
								flag_next = 1'b1;
								acc_next = `TMOE_ACC_RST;
								state_next = tmoe_pkg::ST_FINISH;
							end else begin
								flag_next = 1'b0;
								state_next = tmoe_pkg::ST_RD;
							end
						end
						default: begin
							state_next = tmoe_pkg::ST_FINISH;
						end
					endcase
				end
			end
			tmoe_pkg::ST_RD: begin
				mem_next.rd = 1'b1;
				mem_next.addr = addr_reg;
				state_next = tmoe_pkg::ST_WT;
			end
			tmoe_pkg::ST_WT: begin
				state_next = tmoe_pkg::ST_DT;
			end
			tmoe_pkg::ST_DT: begin
				case (op_reg)
					tmoe_pkg::OP_COPY: begin
						// words past the area end are overwritten as well
						mem_next.we = 1'b1;
						mem_next.addr = aux_reg + idx_reg;
						mem_next.wdata = mem_rdata;
						idx_next = idx_inc;
						addr_next = base_reg + idx_inc;
						state_next = (idx_inc == cnt_reg) ? tmoe_pkg::ST_FINISH : tmoe_pkg::ST_RD;
					end
					tmoe_pkg::OP_BSET: begin
						mem_next.we = 1'b1;
						mem_next.addr = addr_reg;
						mem_next.wdata = mem_rdata | mask_reg;
						state_next = tmoe_pkg::ST_FINISH;
					end
					tmoe_pkg::OP_BCLR: begin
						mem_next.we = 1'b1;
						mem_next.addr = addr_reg;
						mem_next.wdata = mem_rdata & ~mask_reg;
						state_next = tmoe_pkg::ST_FINISH;
					end
					tmoe_pkg::OP_FILL: begin
						// a pointer source costs a second read through the fetched address
						if (src_reg == tmoe_pkg::FILL_PTR && !hop_reg) begin
							hop_next = 1'b1;
							addr_next = mem_rdata;
							state_next = tmoe_pkg::ST_RD;
						end else begin
							data_next = mem_rdata;
							state_next = (cnt_reg == '0) ? tmoe_pkg::ST_FINISH : tmoe_pkg::ST_FILL_WR;
						end
					end
					tmoe_pkg::OP_FIND: begin
						if (mem_rdata == data_reg) begin
							acc_next = `TMOE_ACC_BITS'(idx_reg);
							flag_next = 1'b0;
							state_next = tmoe_pkg::ST_FINISH;
						end else if (idx_inc == cnt_reg) begin
							acc_next = `TMOE_ACC_RST;
							flag_next = 1'b1;
							state_next = tmoe_pkg::ST_FINISH;
						end else begin
							idx_next = idx_inc;
							addr_next = addr_reg + `TMOE_WORD_BITS'(1);
							state_next = tmoe_pkg::ST_RD;
						end
					end
					default: begin
						state_next = tmoe_pkg::ST_FINISH;
					end
				endcase
			end
			tmoe_pkg::ST_FILL_WR: begin
				// one write per cycle, lowest address first
				mem_next.we = 1'b1;
				mem_next.addr = base_reg + idx_reg;
				mem_next.wdata = data_reg;
				idx_next = idx_inc;
				state_next = (idx_inc == cnt_reg) ? tmoe_pkg::ST_FINISH : tmoe_pkg::ST_FILL_WR;
			end
			tmoe_pkg::ST_FINISH: begin
				done_next = 1'b1;
				state_next = tmoe_pkg::ST_IDLE;
			end
			default: begin
				state_next = tmoe_pkg::ST_IDLE;
			end
		endcase
		busy_next = (state_next != tmoe_pkg::ST_IDLE);
	end

	// state registers, synchronous active-low reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= tmoe_pkg::ST_IDLE;
			op_reg <= tmoe_pkg::OP_COPY;
			src_reg <= tmoe_pkg::FILL_IMM;
			hop_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			flag_reg <= 1'b0;
			acc_reg <= `TMOE_ACC_RST;
			base_reg <= `TMOE_WORD_RST;
			aux_reg <= `TMOE_WORD_RST;
			cnt_reg <= `TMOE_WORD_RST;
			idx_reg <= `TMOE_WORD_RST;
			data_reg <= `TMOE_WORD_RST;
			mask_reg <= `TMOE_WORD_RST;
			addr_reg <= `TMOE_WORD_RST;
			mem_reg <= '0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			src_reg <= src_next;
			hop_reg <= hop_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			flag_reg <= flag_next;
			acc_reg <= acc_next;
			base_reg <= base_next;
			aux_reg <= aux_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			data_reg <= data_next;
			mask_reg <= mask_next;
			addr_reg <= addr_next;
			mem_reg <= mem_next;
		end
	end

	// outputs straight from flops
	assign mem_req = mem_reg;
	assign busy = busy_reg;
	assign done = done_reg;
	assign acc_out = acc_reg;
	assign table_range_fault_flag = flag_reg;

	// checks on the engine's own behaviour
	a_single_port: assert property (@(posedge clock) disable iff (!rst_n)
		!(mem_reg.rd && mem_reg.we))
		else $error("read and write on the memory port together");
	a_bit_fault_nowrite: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_IDLE && start && !in_range &&
		(cmd.op == tmoe_pkg::OP_BSET || cmd.op == tmoe_pkg::OP_BCLR))
		|=> (flag_reg && !mem_reg.we) ##1 (done_reg && !mem_reg.we))
		else $error("out of range bit op did not fault cleanly");
	a_bit_set_one: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_DT && op_reg == tmoe_pkg::OP_BSET)
		|=> mem_reg.we && mem_reg.addr == $past(addr_reg) && $onehot($past(mask_reg)) &&
		mem_reg.wdata == ($past(mem_rdata) | $past(mask_reg)))
		else $error("bit set wrote wrong word");
	a_bit_clr_zero: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_DT && op_reg == tmoe_pkg::OP_BCLR)
		|=> mem_reg.we && mem_reg.wdata == ($past(mem_rdata) & ~$past(mask_reg)))
		else $error("bit clear wrote wrong word");
	a_copy_dest: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_DT && op_reg == tmoe_pkg::OP_COPY)
		|=> mem_reg.we && mem_reg.addr == `TMOE_WORD_BITS'($past(aux_reg) + $past(idx_reg)))
		else $error("copy wrote to wrong destination");
	a_find_begin: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_IDLE && start && cmd.op == tmoe_pkg::OP_FIND &&
		acc_in[`TMOE_WORD_BITS-1:0] < len2)
		|=> idx_reg == $past(acc_in[`TMOE_WORD_BITS-1:0]) ##1
		(mem_reg.rd && mem_reg.addr == `TMOE_WORD_BITS'($past(base_reg) + $past(idx_reg))))
		else $error("search did not start at offset");
	a_find_hit: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_DT && op_reg == tmoe_pkg::OP_FIND && mem_rdata == data_reg)
		|=> (acc_reg == `TMOE_ACC_BITS'($past(idx_reg)) && !flag_reg) ##1 done_reg)
		else $error("search hit returned wrong offset");
	a_find_miss: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_DT && op_reg == tmoe_pkg::OP_FIND &&
		mem_rdata != data_reg && idx_inc == cnt_reg)
		|=> acc_reg == `TMOE_ACC_RST && flag_reg)
		else $error("search miss not reported");
	a_fill_value: assert property (@(posedge clock) disable iff (!rst_n)
		(state_reg == tmoe_pkg::ST_FILL_WR)
		|=> mem_reg.we && mem_reg.wdata == $past(data_reg) &&
		mem_reg.addr == `TMOE_WORD_BITS'($past(base_reg) + $past(idx_reg)))
		else $error("fill wrote wrong value or address");
	a_flag_scan_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(scan_end && state_reg == tmoe_pkg::ST_IDLE && !start) |=> !flag_reg)
		else $error("flag survived scan end");
	a_start_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		(start && state_reg != tmoe_pkg::ST_IDLE) |=> op_reg == $past(op_reg))
		else $error("start accepted while busy");
endmodule : tmoe_engine
`default_nettype wire

// [tmoe_mem_model.sv]
// behavioural single-port data memory standing behind the engine
`timescale 1ns/10ps
`default_nettype none
`include "tmoe_defs.svh"

module tmoe_mem_model (
	input wire logic clock,
	input wire tmoe_pkg::tmoe_mem_req_t mem_req,
	output logic [`TMOE_WORD_BITS-1:0] mem_rdata,
	output logic port_clash
);
	logic [`TMOE_WORD_BITS-1:0] mem [0:65535];

	// blank memory so untouched words read as zero
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 16'h0000;
		end
		mem_rdata = 16'h0000;
		port_clash = 1'h0;
	end

	// one access per edge; read data lives one cycle, then flips so stale use shows
	always @(posedge clock) begin
		if (mem_req.rd && mem_req.we) begin
			port_clash <= 1'h1; // single port, never both
		end
		if (mem_req.we) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
		if (mem_req.rd) begin
			mem_rdata <= mem[mem_req.addr];
		end else begin
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : tmoe_mem_model
`default_nettype wire

// [tmoe_pkg.sv]
// types shared by the table memory operation engine
`include "tmoe_defs.svh"

package tmoe_pkg;

	// table operations accepted on a start pulse
	typedef enum logic [2:0] {
		OP_COPY,
		OP_BSET,
		OP_BCLR,
		OP_FILL,
		OP_FIND
	} tmoe_op_t;

	// where a fill takes its value from
	typedef enum logic [1:0] {
		FILL_IMM,
		FILL_MEM,
		FILL_PTR
	} tmoe_fill_src_t;

	// engine sequencing states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RD,
		ST_WT,
		ST_DT,
		ST_FILL_WR,
		ST_FINISH
	} tmoe_state_t;

	// command from the sequencer
	typedef struct packed {
		tmoe_op_t op;
		tmoe_fill_src_t src;
		logic [`TMOE_WORD_BITS-1:0] operand;
	} tmoe_cmd_t;

	// single data memory port request
	typedef struct packed {
		logic rd;
		logic we;
		logic [`TMOE_WORD_BITS-1:0] addr;
		logic [`TMOE_WORD_BITS-1:0] wdata;
	} tmoe_mem_req_t;

endpackage : tmoe_pkg
